// ==== inc/bdlic_pkg.sv ====
// Constants and types for the buffered DIMM link bring-up block
package bdlic_pkg;
  // Channel state setting encodings
  typedef enum logic [2:0] {
    BDLIC_DISABLE   = 3'h0,
    BDLIC_CALIBRATE = 3'h1,
    BDLIC_TRAINING  = 3'h2,
    BDLIC_TESTING   = 3'h3,
    BDLIC_POLLING   = 3'h4,
    BDLIC_CONFIG    = 3'h5,
    BDLIC_OPER      = 3'h6
  } bdlic_chan_t;

  // Southbound lane drive selection
  typedef enum logic [2:0] {
    BDLIC_TX_IDLE,
    BDLIC_TX_PAT1,
    BDLIC_TX_PAT2_HDR,
    BDLIC_TX_ENGINE,
    BDLIC_TX_PAT2_TRL,
    BDLIC_TX_PAT3,
    BDLIC_TX_PAT4,
    BDLIC_TX_CMD
  } bdlic_tx_t;

  // Link framing
  localparam int          FRAME_CYCLES    = 12;
  localparam int          DISABLE_FRAMES  = 51;
  localparam int          CLKTRAIN_FRAMES = 42;
  localparam int          SB_LANES        = 10;
  localparam int          NB_LANES        = 14;
  localparam int          NB_LANES_MIN    = 13;
  localparam int          SB_LANES_MIN    = 9;
  localparam int          NOP_COUNT       = 4;
  localparam logic [3:0]  FRAME_LAST      = 4'(FRAME_CYCLES - 1);
  localparam logic [5:0]  DISABLE_MIN     = 6'(DISABLE_FRAMES);
  localparam logic [2:0]  NOP_LAST        = 3'(NOP_COUNT);
  localparam logic [7:0]  LOOP_MAX        = 8'h00ff;

  // Command word fields
  localparam int DS_HI = 23;
  localparam int DS_LO = 21;
  localparam int ACT_BIT = 20;
  localparam int OP_HI = 20;
  localparam int OP_LO = 18;
  localparam int RS_BIT = 17;
  localparam int CODE_HI = 20;
  localparam int CODE_LO = 14;
  localparam int BC_BIT = 13;
  localparam int SUB_HI = 12;
  localparam int SUB_LO = 10;
  localparam int WADDR_HI = 10;
  localparam int WADDR_LO = 2;
  localparam int DE_HI = 7;

  localparam logic [2:0] OP_WRITE = 3'h3;
  localparam logic [2:0] OP_READ  = 3'h2;
  localparam logic [2:0] SUB_PREA = 3'h7;
  localparam logic [2:0] SUB_PRES = 3'h6;
  localparam logic [2:0] SUB_AREF = 3'h5;
  localparam logic [2:0] SUB_SREN = 3'h4;
  localparam logic [2:0] SUB_SRX  = 3'h3;
  localparam logic [2:0] SUB_PDEN = 3'h2;

  localparam logic [6:0] CC_NOP    = 7'h00;
  localparam logic [6:0] CC_SYNC   = 7'h01;
  localparam logic [6:0] CC_SRST   = 7'h02;
  localparam logic [6:0] CC_RSVD   = 7'h03;
  localparam logic [6:0] CC_CFGRD  = 7'h04;
  localparam logic [6:0] CC_CFGWR  = 7'h05;
  localparam logic [6:0] CC_CKERK  = 7'h06;
  localparam logic [6:0] CC_CKEDM  = 7'h07;
  localparam logic [6:0] CC_DBGEX  = 7'h0e;
  localparam logic [6:0] CC_DBG    = 7'h0f;

  // Decoded command kinds
  typedef enum logic [4:0] {
    K_ACT, K_WR, K_RD, K_PREA, K_PRES, K_AREF, K_SREN, K_SRX, K_PDEN,
    K_NOP, K_SYNC, K_SRST, K_CFGWR, K_CFGRD, K_CKEDM, K_CKERK,
    K_DBGEV, K_DBGRT, K_DBGEX, K_RSVD
  } bdlic_kind_t;

  localparam logic [23:0] NOP_WORD = 24'h00_0000;
endpackage

// ==== verilog/bdlic_loop_mem.sv ====
// Small memory of loopback counters, one word per northbound lane
module bdlic_loop_mem (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       clr,
  input  wire logic [3:0] wr_idx,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  input  wire logic [3:0] rd_idx,
  output logic      [7:0] rd_data_ff
);
  logic [7:0] mem_ff [bdlic_pkg::NB_LANES];

  // Counter store; clear beats a write in the same cycle so Training starts from zero
  always_ff @(posedge clk_sys) begin
    if (!rst_n || clr) begin
      for (int i = 0; i < bdlic_pkg::NB_LANES; i++) begin
        mem_ff[i] <= 8'h00;
      end
    end else if (wr_en) begin
      mem_ff[wr_idx] <= wr_data;
    end
  end

  // Registered read port
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_data_ff <= 8'h00;
    end else begin
      rd_data_ff <= (rd_idx < 4'(bdlic_pkg::NB_LANES)) ? mem_ff[rd_idx] : 8'h00;
    end
  end
endmodule // bdlic_loop_mem

// ==== verilog/bdlic_top.sv ====
// Channel bring-up sequencer and southbound command encoder
module bdlic_top (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  input  wire bdlic_pkg::bdlic_chan_t  chan_state,
  input  wire logic                    nb_frame_ok,
  input  wire logic [13:0]             nb_lane_ok,
  input  wire logic [2:0]              nb_buffer_id,
  input  wire logic [2:0]              last_buffer_id,
  input  wire logic                    engine_done,
  input  wire logic [3:0]              loop_rd_idx,
  input  wire logic                    cmd_valid,
  input  wire logic [23:0]             cmd_word,
  output bdlic_pkg::bdlic_tx_t         tx_sel_ff,
  output logic                         sb_idle_ff,
  output logic                         frame_start_ff,
  output logic                         engine_go_ff,
  output logic [2:0]                   pattern_target_ff,
  output logic [23:0]                  sb_cmd_ff,
  output logic                         cmd_ready_ff,
  output bdlic_pkg::bdlic_kind_t       cmd_kind_ff,
  output logic [2:0]                   cmd_dimm_ff,
  output logic                         cmd_rank_ff,
  output logic [8:0]                   cmd_waddr_ff,
  output logic                         cmd_bcast_ff,
  output logic                         pattern_seen_ff,
  output logic                         lanes_good_ff,
  output logic                         disable_met_ff,
  output logic [7:0]                   loop_count_ff
);
  import bdlic_pkg::*;

  // Decoding of a command word into its kind
  function automatic bdlic_kind_t decode_kind(input logic [23:0] w);
    logic [6:0] code;
    logic [2:0] op;
    logic [2:0] sub;
    code = w[CODE_HI:CODE_LO];
    op   = w[OP_HI:OP_LO];
    sub  = w[SUB_HI:SUB_LO];
    decode_kind = K_RSVD;
    if (w[ACT_BIT]) begin
      decode_kind = K_ACT;
    end else if (op == OP_WRITE) begin
      decode_kind = K_WR;
    end else if (op == OP_READ) begin
      decode_kind = K_RD;
    end else if (sub[2] || sub[1]) begin
      case (sub)
        SUB_PREA: decode_kind = K_PREA;
        SUB_PRES: decode_kind = K_PRES;
        SUB_AREF: decode_kind = K_AREF;
        SUB_SREN: decode_kind = K_SREN;
        SUB_SRX:  decode_kind = K_SRX;
        SUB_PDEN: decode_kind = K_PDEN;
        default:  decode_kind = K_RSVD;
      endcase
    end else begin
      case (code)
        CC_NOP:   decode_kind = K_NOP;
        CC_SYNC:  decode_kind = K_SYNC;
        CC_SRST:  decode_kind = K_SRST;
        CC_CFGWR: decode_kind = K_CFGWR;
        CC_CFGRD: decode_kind = K_CFGRD;
        CC_CKEDM: decode_kind = K_CKEDM;
        CC_CKERK: decode_kind = K_CKERK;
        CC_DBG:   decode_kind = w[BC_BIT] ? K_DBGEV : K_DBGRT;
        CC_DBGEX: decode_kind = K_DBGEX;
        default:  decode_kind = K_RSVD;
      endcase
    end
  endfunction

  // Frame timing and state tracking registers
  logic [3:0]  beat_ff;
  logic [5:0]  dis_frames_ff;
  logic [2:0]  nop_cnt_ff;
  bdlic_chan_t prev_state_ff;
  logic        in_engine_ff;

  // Frame boundary and lane quality
  wire         frame_end  = (beat_ff == FRAME_LAST);
  wire         state_chg  = (chan_state != prev_state_ff);
  wire  [3:0]  lanes_up   = 4'($countones(nb_lane_ok));
  wire         lanes_pass = (lanes_up >= 4'(NB_LANES_MIN));
  wire         last_ret   = nb_frame_ok && (nb_buffer_id == last_buffer_id);
  wire         ops_ready  = (chan_state == BDLIC_OPER) && (nop_cnt_ff == NOP_LAST);
  wire         cmd_take   = ops_ready && cmd_valid && frame_end;
  wire  [7:0]  loop_rd;
  logic [3:0]  upd_idx_ff;

  // Lane drive choice for each setting
  bdlic_tx_t nxt_tx_sel;
  always_comb begin
    case (chan_state)
      BDLIC_DISABLE:   nxt_tx_sel = BDLIC_TX_IDLE;
      BDLIC_CALIBRATE: nxt_tx_sel = BDLIC_TX_IDLE;
      BDLIC_TRAINING:  nxt_tx_sel = BDLIC_TX_PAT1;
      BDLIC_TESTING: begin
        if (in_engine_ff) begin
          nxt_tx_sel = engine_done ? BDLIC_TX_PAT2_TRL : BDLIC_TX_ENGINE;
        end else begin
          nxt_tx_sel = BDLIC_TX_PAT2_HDR;
        end
      end
      BDLIC_POLLING:   nxt_tx_sel = BDLIC_TX_PAT3;
      BDLIC_CONFIG:    nxt_tx_sel = BDLIC_TX_PAT4;
      BDLIC_OPER:      nxt_tx_sel = BDLIC_TX_CMD;
      default:         nxt_tx_sel = BDLIC_TX_IDLE;
    endcase
  end

  // Frame beat counter, restarted on each setting change
  always_ff @(posedge clk_sys) begin
    if (!rst_n || state_chg) begin
      beat_ff <= 4'h0;
    end else begin
      beat_ff <= frame_end ? 4'h0 : beat_ff + 4'h1;
    end
  end

  // Setting history and Disable frame count, saturating at the minimum
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prev_state_ff <= BDLIC_DISABLE;
      dis_frames_ff <= 6'h00;
    end else begin
      prev_state_ff <= chan_state;
      if (chan_state != BDLIC_DISABLE) begin
        dis_frames_ff <= 6'h00;
      end else if (frame_end && dis_frames_ff != DISABLE_MIN) begin
        dis_frames_ff <= dis_frames_ff + 6'h01;
      end
    end
  end

  // Testing sub-sequence: header, engine hand-off, trailer, repeat
  always_ff @(posedge clk_sys) begin
    if (!rst_n || chan_state != BDLIC_TESTING) begin
      in_engine_ff <= 1'b0;
    end else if (in_engine_ff && engine_done) begin
      in_engine_ff <= 1'b0;
    end else if (!in_engine_ff && frame_end) begin
      in_engine_ff <= 1'b1;
    end
  end

  // NOP count after entering the operational state
  always_ff @(posedge clk_sys) begin
    if (!rst_n || chan_state != BDLIC_OPER) begin
      nop_cnt_ff <= 3'h0;
    end else if (frame_end && nop_cnt_ff != NOP_LAST) begin
      nop_cnt_ff <= nop_cnt_ff + 3'h1;
    end
  end

  // Southbound outputs: command word is a NOP until four have gone out
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_sel_ff         <= BDLIC_TX_IDLE;
      sb_idle_ff        <= 1'b1;
      frame_start_ff    <= 1'b0;
      engine_go_ff      <= 1'b0;
      pattern_target_ff <= 3'h0;
      sb_cmd_ff         <= NOP_WORD;
      cmd_ready_ff      <= 1'b0;
    end else begin
      tx_sel_ff         <= nxt_tx_sel;
      sb_idle_ff        <= (nxt_tx_sel == BDLIC_TX_IDLE);
      frame_start_ff    <= frame_end;
      engine_go_ff      <= (nxt_tx_sel == BDLIC_TX_ENGINE);
      pattern_target_ff <= last_buffer_id;
      sb_cmd_ff         <= cmd_take ? cmd_word : NOP_WORD;
      cmd_ready_ff      <= cmd_take;
    end
  end

  // Fields of the command taken, for the frame builder
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cmd_kind_ff  <= K_NOP;
      cmd_dimm_ff  <= 3'h0;
      cmd_rank_ff  <= 1'b0;
      cmd_waddr_ff <= 9'h000;
      cmd_bcast_ff <= 1'b0;
    end else if (cmd_take) begin
      cmd_kind_ff  <= decode_kind(cmd_word);
      cmd_dimm_ff  <= cmd_word[DS_HI:DS_LO];
      cmd_rank_ff  <= cmd_word[RS_BIT];
      cmd_waddr_ff <= cmd_word[WADDR_HI:WADDR_LO];
      cmd_bcast_ff <= cmd_word[BC_BIT];
    end
  end

  // Status seen by software, which alone decides when to advance
  always_ff @(posedge clk_sys) begin
    if (!rst_n || state_chg) begin
      pattern_seen_ff <= 1'b0;
      lanes_good_ff   <= 1'b0;
      disable_met_ff  <= 1'b0;
    end else begin
      pattern_seen_ff <= pattern_seen_ff || last_ret;
      lanes_good_ff   <= lanes_pass;
      disable_met_ff  <= (dis_frames_ff == DISABLE_MIN);
    end
  end

  // Write index for loopback count updates: the read index, one cycle late
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      upd_idx_ff <= 4'h0;
    end else begin
      upd_idx_ff <= loop_rd_idx;
    end
  end

  // Loopback counter of the lane picked by loop_rd_idx counts its good first patterns in Training
  wire       loop_wr  = (chan_state == BDLIC_TRAINING) && nb_frame_ok
                        && nb_lane_ok[upd_idx_ff] && (loop_rd != LOOP_MAX);
  wire [7:0] loop_inc = loop_rd + 8'h01;
  wire       loop_clr = state_chg && (chan_state == BDLIC_TRAINING);

  bdlic_loop_mem u_loop (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .clr        (loop_clr),
    .wr_idx     (upd_idx_ff),
    .wr_en      (loop_wr),
    .wr_data    (loop_inc),
    .rd_idx     (loop_rd_idx),
    .rd_data_ff (loop_rd)
  );

  // Loopback count for the selected lane
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      loop_count_ff <= 8'h00;
    end else begin
      loop_count_ff <= loop_rd;
    end
  end
endmodule // bdlic_top

// ==== verification/bdlic_top_props.sv ====
// Assertions on the ports of the bring-up sequencer
module bdlic_top_props (
  input wire logic                   clk_sys,
  input wire logic                   rst_n,
  input wire bdlic_pkg::bdlic_chan_t chan_state,
  input wire logic [13:0]            nb_lane_ok,
  input wire logic [2:0]             last_buffer_id,
  input wire logic                   engine_done,
  input wire logic                   cmd_valid,
  input wire logic [23:0]            cmd_word,
  input wire bdlic_pkg::bdlic_tx_t   tx_sel_ff,
  input wire logic                   sb_idle_ff,
  input wire logic                   frame_start_ff,
  input wire logic                   engine_go_ff,
  input wire logic [2:0]             pattern_target_ff,
  input wire logic [23:0]            sb_cmd_ff,
  input wire logic                   cmd_ready_ff,
  input wire logic [2:0]             cmd_dimm_ff,
  input wire logic                   cmd_rank_ff,
  input wire logic                   lanes_good_ff
);
  import bdlic_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [6:0] oper_cnt_ff;
  // Cycles in operational state; saturates so a long run never wraps
  always_ff @(posedge clk_sys) begin
    if (!rst_n || chan_state != BDLIC_OPER) oper_cnt_ff <= 7'h00;
    else if (oper_cnt_ff != 7'h7f) oper_cnt_ff <= oper_cnt_ff + 7'h01;
  end
  property p_idle;
    chan_state == BDLIC_DISABLE |=> sb_idle_ff && tx_sel_ff == BDLIC_TX_IDLE;
  endproperty
  a_idle: assert property (p_idle) else $error("lanes not idle");
  property p_pat1;
    chan_state == BDLIC_TRAINING |=> tx_sel_ff == BDLIC_TX_PAT1
      && pattern_target_ff == last_buffer_id;
  endproperty
  a_pat1: assert property (p_pat1) else $error("first pattern missing");
  property p_pat34;
    chan_state inside {BDLIC_POLLING, BDLIC_CONFIG} |=> tx_sel_ff ==
      ($past(chan_state) == BDLIC_POLLING ? BDLIC_TX_PAT3 : BDLIC_TX_PAT4);
  endproperty
  a_pat34: assert property (p_pat34) else $error("wrong pattern");
  property p_nop;
    cmd_ready_ff |-> oper_cnt_ff >= 7'h2c;
  endproperty
  a_nop: assert property (p_nop) else $error("command before preamble");
  property p_quiet;
    !cmd_ready_ff |-> sb_cmd_ff == NOP_WORD;
  endproperty
  a_quiet: assert property (p_quiet) else $error("idle frame not empty");
  property p_take;
    cmd_ready_ff |-> $past(cmd_valid) && sb_cmd_ff == $past(cmd_word);
  endproperty
  a_take: assert property (p_take) else $error("wrong word sent");
  property p_fld;
    cmd_ready_ff |-> cmd_dimm_ff == sb_cmd_ff[23:21] && cmd_rank_ff == sb_cmd_ff[17];
  endproperty
  a_fld: assert property (p_fld) else $error("wrong select fields");
  property p_frame;
    frame_start_ff |=> !frame_start_ff [*8] ##1 !frame_start_ff [*3];
  endproperty
  a_frame: assert property (p_frame) else $error("frame too short");
  property p_trl;
    engine_go_ff && engine_done |-> ##[1:2] tx_sel_ff == BDLIC_TX_PAT2_TRL;
  endproperty
  a_trl: assert property (p_trl) else $error("trailer missing");
  // A setting change or reset clears the vote for a cycle, so the window restarts there
  property p_good;
    $stable({nb_lane_ok, chan_state, rst_n}) [*3] |-> lanes_good_ff ==
      ($countones(nb_lane_ok) >= NB_LANES_MIN);
  endproperty
  a_good: assert property (p_good) else $error("lane vote wrong");
endmodule // bdlic_top_props

bind bdlic_top bdlic_top_props bdlic_top_props_i (.clk_sys, .rst_n, .chan_state,
  .nb_lane_ok, .last_buffer_id, .engine_done, .cmd_valid, .cmd_word, .tx_sel_ff,
  .sb_idle_ff, .frame_start_ff, .engine_go_ff, .pattern_target_ff, .sb_cmd_ff,
  .cmd_ready_ff, .cmd_dimm_ff, .cmd_rank_ff, .lanes_good_ff);

// ==== verification/bdlic_chain_model.sv ====
// Behavioural chain of memory buffer chips beyond the link
module bdlic_chain_model (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire bdlic_pkg::bdlic_tx_t tx_sel_ff,
  input  wire logic                 frame_start_ff,
  input  wire logic [2:0]           pattern_target_ff,
  input  wire logic                 engine_go_ff,
  input  wire logic [2:0]           lat,
  input  wire logic [13:0]          bad_lanes,
  output logic                      nb_frame_ok,
  output logic [13:0]               nb_lane_ok,
  output logic [2:0]                nb_buffer_id,
  output logic                      engine_done
);
  import bdlic_pkg::*;
  logic [7:0] echo_ff;
  logic [4:0] run_ff;
  // Failing lanes never report good, whatever the traffic
  assign nb_lane_ok = ~bad_lanes;
  // Patterns return lat+2 cycles after the frame start; the id line toggles in between
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      echo_ff <= 8'h00;
      nb_frame_ok <= 1'b0;
      nb_buffer_id <= 3'h0;
      run_ff <= 5'h00;
      engine_done <= 1'b0;
    end else begin
      echo_ff <= {echo_ff[6:0],
                  frame_start_ff && !(tx_sel_ff inside {BDLIC_TX_IDLE, BDLIC_TX_CMD})};
      nb_frame_ok <= echo_ff[lat];
      // Addressed buffer answers with its id; merge errors stay inside the buffers
      nb_buffer_id <= echo_ff[lat] ? pattern_target_ff : ~nb_buffer_id;
      run_ff <= engine_go_ff ? run_ff + 5'h01 : 5'h00;
      engine_done <= run_ff == {lat, 2'h3};
    end
  end
endmodule // bdlic_chain_model

// ==== verification/testbench.sv ====
// Self-checking bench for the link bring-up block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import bdlic_pkg::*;
  logic clk_sys, rst_n, cmd_valid, nb_frame_ok, engine_done;
  logic [2:0] lat, last_buffer_id, nb_buffer_id, pattern_target_ff, cmd_dimm_ff;
  logic [3:0] loop_rd_idx;
  logic [13:0] bad_lanes, nb_lane_ok;
  logic [23:0] cmd_word, sb_cmd_ff, w;
  logic [7:0] loop_count_ff;
  logic [8:0] cmd_waddr_ff;
  logic sb_idle_ff, frame_start_ff, engine_go_ff, cmd_ready_ff, cmd_rank_ff;
  logic cmd_bcast_ff, pattern_seen_ff, lanes_good_ff, disable_met_ff;
  logic [42:0] e;
  logic [42:0] q[$];
  logic [6:0] codes [11] = '{CC_NOP, CC_SYNC, CC_SRST, CC_RSVD, CC_CFGRD, CC_CFGWR,
    CC_CKERK, CC_CKEDM, CC_DBGEX, CC_DBG, CC_DBG};
  logic [2:0] op3 [3] = '{3'h4, OP_WRITE, OP_READ};
  bdlic_chan_t chan_state;
  bdlic_tx_t tx_sel_ff;
  bdlic_kind_t cmd_kind_ff;
  int n_fail, n_compared, seed;
  bdlic_top bdlic_top_i (.*);
  bdlic_chain_model bdlic_chain_model_i (.*);
  // Free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic go(input bdlic_chan_t s, input int n);
    chan_state <= s;
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic until_seen;
    repeat (300) begin
      @(posedge clk_sys);
      if (pattern_seen_ff === 1'b1) break;
    end
  endtask
  // Decode kept apart from the design's own decoder
  function automatic bdlic_kind_t kind_of(input logic [23:0] x);
    if (x[20]) return K_ACT;
    if (x[19:18] == 2'h3) return K_WR;
    if (x[19:18] == 2'h2) return K_RD;
    if (x[12] || x[11]) return bdlic_kind_t'(5'h0a - 5'(x[12:10]));
    case (x[20:14])
      CC_NOP: return K_NOP;
      CC_SYNC: return K_SYNC;
      CC_SRST: return K_SRST;
      CC_CFGWR: return K_CFGWR;
      CC_CFGRD: return K_CFGRD;
      CC_CKEDM: return K_CKEDM;
      CC_CKERK: return K_CKERK;
      CC_DBGEX: return K_DBGEX;
      CC_DBG: return x[13] ? K_DBGEV : K_DBGRT;
      default: return K_RSVD;
    endcase
  endfunction
  // Holds the word until the acceptance pulse shows
  task automatic send(input logic [23:0] x);
    q.push_back({kind_of(x), x[23:21], x[17], x[10:2], x[13], x});
    cmd_word <= x;
    cmd_valid <= 1'b1;
    repeat (100) begin
      @(posedge clk_sys);
      if (cmd_ready_ff === 1'b1) break;
    end
    chk(cmd_ready_ff, 1);
  endtask
  // Oldest note is matched against each accepted command
  always @(negedge clk_sys) begin
    if (cmd_ready_ff === 1'b1) begin
      e = q.pop_front();
      chk(sb_cmd_ff, e[23:0]);
      @(negedge clk_sys);
      chk({cmd_kind_ff, cmd_dimm_ff, cmd_rank_ff, cmd_waddr_ff, cmd_bcast_ff}, e[42:24]);
    end
  end
  // Cuts a hung run short
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    wrap_up();
  end
  // Software-style bring-up, then random command traffic
  initial begin
    seed = 32'h83f3_1a86;
    {rst_n, cmd_valid, cmd_word, lat, bad_lanes} = '0;
    chan_state = BDLIC_DISABLE;
    last_buffer_id = 3'h5;
    loop_rd_idx = 4'h5;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    go(BDLIC_DISABLE, 480);
    chk(disable_met_ff, 0);
    go(BDLIC_DISABLE, 144);
    chk(disable_met_ff, 1);
    chk(sb_idle_ff, 1);
    go(BDLIC_CALIBRATE, 1020);
    go(BDLIC_DISABLE, 624);
    lat <= 3'h2;
    bad_lanes <= 14'h0020;
    go(BDLIC_TRAINING, 60);
    loop_rd_idx <= 4'h1;
    until_seen();
    chk(pattern_seen_ff, 1);
    go(BDLIC_TRAINING, 24);
    chk(loop_count_ff != 8'h00, 1);
    chk(lanes_good_ff, 1);
    loop_rd_idx <= 4'h5;
    bad_lanes <= 14'h0020 | (14'h0040 << ($unsigned($random(seed)) % 8));
    go(BDLIC_TRAINING, 3);
    chk(loop_count_ff, 0);
    chk(lanes_good_ff, 0);
    bad_lanes <= 14'h0020;
    go(BDLIC_TESTING, 80);
    chk(pattern_seen_ff, 1);
    chk(lanes_good_ff, 1);
    chk(pattern_target_ff, 3'h5);
    lat <= 3'h7;
    go(BDLIC_POLLING, 2);
    until_seen();
    chk(pattern_seen_ff, 1);
    chk(tx_sel_ff, BDLIC_TX_PAT3);
    go(BDLIC_CONFIG, 2);
    cmd_valid <= 1'b1;
    until_seen();
    chk(pattern_seen_ff, 1);
    chk(tx_sel_ff, BDLIC_TX_PAT4);
    go(BDLIC_OPER, 0);
    for (int i = 0; i < 20; i++) begin
      w = 24'($random(seed));
      if (i < 6) begin
        w[20:18] = {2'h0, i[0]};
        w[12:10] = 3'(i + 2);
      end else if (i < 17) begin
        w[20:14] = codes[i - 6];
        w[12:11] = 2'h0;
        w[13] = i[0];
      end else w[20:18] = op3[i - 17];
      send(w);
    end
    cmd_valid <= 1'b0;
    repeat (30) @(posedge clk_sys);
    chk(q.size(), 0);
    wrap_up();
  end
endmodule // testbench
